// ==== src/lcd_blink_defs.svh ====
`ifndef LCD_BLINK_DEFS_SVH
`define LCD_BLINK_DEFS_SVH

// Byte offsets on the register port
`define OFS_BLINK_CTL   8'h00
`define OFS_MUX_CTL     8'h01
`define OFS_MEM_CTL     8'h02
`define OFS_VOLT_CTL    8'h03
`define OFS_FLAGS       8'h04
`define OFS_SEG_MEM     8'h20
`define OFS_BLINK_MEM   8'h40

// Blink control fields
`define MODE_LSB        0
`define PRE_LSB         2
// Memory control fields
`define DISP_SEL_BIT    0
`define CLR_BM_BIT      1
// Voltage control fields
`define VLEVEL_LSB      0
`define SUPPLY_SEL_BIT  4
`define REF_EN_BIT      5
`define PUMP_EN_BIT     6
`define AUTO_STOP_BIT   7
// Flag fields
`define ON_FLAG_BIT     0
`define OFF_FLAG_BIT    1

// Reset values
`define RST_MUX         3'h0
`define RST_PRE         3'h0
`define RST_VLEVEL      4'h0

// Highest mux code that still has a blink memory (4-mux)
`define MUX_DUAL_MAX    3'h3

`endif

// ==== src/lcd_blink_pkg.sv ====
package lcd_blink_pkg;

	typedef enum logic [1:0] {
		BLINK_NONE,
		BLINK_SEGMENT,
		BLINK_ALL,
		BLINK_SWAP
	} blink_mode_t;

	typedef struct packed {
		logic [7:0]  addr;
		logic [15:0] wdata;
		logic        word;
		logic        wr;
		logic        rd;
	} reg_req_t;

	typedef struct packed {
		logic from_vdd;
		logic from_pump;
		logic pump_run;
		logic pump_hold;
	} supply_t;

endpackage : lcd_blink_pkg

// ==== src/byte_mem.sv ====
`timescale 1ns/1ps
module byte_mem (
	input  wire logic         clk,
	input  wire logic         reset,
	input  wire logic         wr_lo,
	input  wire logic         wr_hi,
	input  wire logic [3:0]   idx,
	input  wire logic [15:0]  wdata,
	input  wire logic         clear,
	output logic      [127:0] contents
);
	logic [7:0] mem      [16];
	logic [7:0] next_mem [16];

	always_comb begin
		next_mem = mem;
		if (clear) begin
			for (int i = 0; i < 16; i++) begin
				next_mem[i] = 8'h00;
			end
		end else begin
			if (wr_lo) begin
				next_mem[idx] = wdata[7:0];
			end
			if (wr_hi) begin
				next_mem[4'(idx + 4'h1)] = wdata[15:8];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			for (int i = 0; i < 16; i++) begin
				mem[i] <= 8'h00;
			end
		end else begin
			mem <= next_mem;
		end
	end

	for (genvar g = 0; g < 16; g++) begin : g_flat
		assign contents[8*g +: 8] = mem[g];
	end
endmodule : byte_mem

// ==== src/blink_divider.sv ====
`timescale 1ns/1ps
module blink_divider (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       hold,
	input  wire logic       lcd_tick,
	input  wire logic [2:0] mux_rate_sel,
	input  wire logic [2:0] blink_prescale,
	output logic            blink_clock
);
	logic [12:0] cnt;
	logic [12:0] next_cnt;
	logic [12:0] period;
	logic [12:0] half;
	logic        next_blink_clock;

	always_comb begin
		// (mux + 1) * 2^(prescale + 2), at most 4096
		period = ({10'h000, mux_rate_sel} + 13'h0001) << ({1'b0, blink_prescale} + 4'h2);
		half = period >> 1;
		next_cnt = cnt;
		if (hold) begin
			next_cnt = 13'h0000;
		end else if (lcd_tick) begin
			next_cnt = (cnt == period - 13'h0001) ? 13'h0000 : cnt + 13'h0001;
		end
		// Low half first, so each blink starts blank
		next_blink_clock = !hold && (next_cnt >= half);
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			cnt         <= 13'h0000;
			blink_clock <= 1'b0;
		end else begin
			cnt         <= next_cnt;
			blink_clock <= next_blink_clock;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	chk_div_hold: assert property (hold |=> cnt == 13'h0000 && !blink_clock)
		else $error("divider not held while blinking off");
	chk_div_wrap: assert property (
		!hold && lcd_tick && cnt == period - 13'h0001 |=> cnt == 13'h0000)
		else $error("divider did not wrap at its period");
	chk_div_half: assert property (
		!hold && !lcd_tick && cnt < half |=> !blink_clock)
		else $error("blink clock high in its low half");
endmodule : blink_divider

// ==== src/lcd_blink_dual_memory_ctrl.sv ====
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`include "lcd_blink_defs.svh"
// What this block does
// - Mode 01 at up to 4-mux blinks only segments marked in blink memory.
// - Mode 10 blinks all segments; mode 00 disables blinking.
// - Above 4-mux only mode 10 blinks; other codes give no blinking.
// - Blink memory mirrors display memory layout, one bit per segment.
// - Blink memory accepts 16-bit accesses at even addresses.
// - Clear bit zeroes blink memory at next frame, then drops itself.
// - Blink clock is LCD clock over (mux+1) times 2^(prescale+2).
// - Blink divider held reset while mode is 00.
// - Blinking starts blank at next frame, half period off, half on.
// - Mode 00 at up to 4-mux: select bit picks segment memory (0) or blink memory (1).
// - Memory source changes only at a frame boundary.
// - Mode 11 alternates memories; select bit reads back as status.
// - Mode 11 shows segment memory first half, blink memory second.
// - Supply from main when select=1, ref=0; from pump when select=0, pump=1.
// - Pump stops when disabled with nonzero level or in quiet windows.
// - On flag at blink clock rise, off flag at fall, while blinking.
module lcd_blink_dual_memory_ctrl
	import lcd_blink_pkg::*;
(
	input  wire logic          clk,
	input  wire logic          reset,
	input  wire reg_req_t      bus_req,
	input  wire logic          lcd_tick,
	input  wire logic          frame_strobe,
	input  wire logic          noise_window,
	output logic      [15:0]   rdata,
	output logic      [127:0]  segments,
	output logic               showing_blink_mem,
	output logic               blink_on_flag,
	output logic               blink_off_flag,
	output supply_t            supply
);
	// Control state
	blink_mode_t blink_mode_sel;
	blink_mode_t next_blink_mode_sel;
	logic [2:0]  blink_prescale;
	logic [2:0]  next_blink_prescale;
	logic [2:0]  mux_rate_sel;
	logic [2:0]  next_mux_rate_sel;
	logic        display_mem_select;
	logic        next_display_mem_select;
	logic        clear_blink_mem;
	logic        next_clear_blink_mem;
	logic [3:0]  lcd_voltage_level;
	logic [3:0]  next_lcd_voltage_level;
	logic        supply_select;
	logic        next_supply_select;
	logic        ref_enable;
	logic        next_ref_enable;
	logic        pump_enable;
	logic        next_pump_enable;
	logic        auto_stop;
	logic        next_auto_stop;
	// Frame-aligned display state
	blink_mode_t shown_mode;
	blink_mode_t next_shown_mode;
	logic        phase_on;
	logic        next_phase_on;
	logic        show_blink;
	logic        next_show_blink;
	logic        bc_prev;
	// Outputs
	logic [15:0]  next_rdata;
	logic [127:0] next_segments;
	logic         next_on_flag;
	logic         next_off_flag;
	supply_t      next_supply;
	// Helpers
	logic         blink_clock;
	logic         dual_ok;
	blink_mode_t  eff_mode;
	logic         seg_hit;
	logic         bm_hit;
	logic         wide;
	logic [127:0] seg_flat;
	logic [127:0] bm_flat;
	logic [127:0] src;
	logic [6:0]   lo_pos;
	logic [6:0]   hi_pos;
	logic         quiet;

	function automatic logic in_mem(input logic [7:0] a, input logic [7:0] base);
		return a[7:4] == base[7:4];
	endfunction : in_mem

	function automatic logic wr_at(input reg_req_t r, input logic [7:0] ofs);
		return r.wr && r.addr == ofs;
	endfunction : wr_at

	assign dual_ok = mux_rate_sel <= `MUX_DUAL_MAX;
	assign seg_hit = in_mem(bus_req.addr, `OFS_SEG_MEM);
	assign bm_hit  = in_mem(bus_req.addr, `OFS_BLINK_MEM);
	// A word access at an odd address falls back to a byte access
	assign wide    = bus_req.word && !bus_req.addr[0];
	assign lo_pos  = {bus_req.addr[3:0], 3'h0};
	assign hi_pos  = {bus_req.addr[3:1], 1'b1, 3'h0};
	assign quiet   = auto_stop && noise_window;

	// Above 4-mux only all-segment blinking survives
	always_comb begin
		if (dual_ok) begin
			eff_mode = blink_mode_sel;
		end else if (blink_mode_sel == BLINK_ALL) begin
			eff_mode = BLINK_ALL;
		end else begin
			eff_mode = BLINK_NONE;
		end
	end

	byte_mem u_seg_mem (
		.clk      (clk),
		.reset    (reset),
		.wr_lo    (bus_req.wr && seg_hit),
		.wr_hi    (bus_req.wr && seg_hit && wide),
		.idx      (bus_req.addr[3:0]),
		.wdata    (bus_req.wdata),
		.clear    (1'b0),
		.contents (seg_flat)
	);

	// Same byte layout as the segment memory
	byte_mem u_blink_mem (
		.clk      (clk),
		.reset    (reset),
		.wr_lo    (bus_req.wr && bm_hit),
		.wr_hi    (bus_req.wr && bm_hit && wide),
		.idx      (bus_req.addr[3:0]),
		.wdata    (bus_req.wdata),
		.clear    (clear_blink_mem && frame_strobe),
		.contents (bm_flat)
	);

	blink_divider u_div (
		.clk            (clk),
		.reset          (reset),
		.hold           (blink_mode_sel == BLINK_NONE),
		.lcd_tick       (lcd_tick),
		.mux_rate_sel   (mux_rate_sel),
		.blink_prescale (blink_prescale),
		.blink_clock    (blink_clock)
	);

	// Register writes
	always_comb begin
		next_blink_mode_sel     = blink_mode_sel;
		next_blink_prescale     = blink_prescale;
		next_mux_rate_sel       = mux_rate_sel;
		next_display_mem_select = display_mem_select;
		next_clear_blink_mem    = clear_blink_mem;
		next_lcd_voltage_level  = lcd_voltage_level;
		next_supply_select      = supply_select;
		next_ref_enable         = ref_enable;
		next_pump_enable        = pump_enable;
		next_auto_stop          = auto_stop;
		if (wr_at(bus_req, `OFS_BLINK_CTL)) begin
			next_blink_mode_sel = blink_mode_t'(bus_req.wdata[`MODE_LSB +: 2]);
			next_blink_prescale = bus_req.wdata[`PRE_LSB +: 3];
		end
		if (wr_at(bus_req, `OFS_MUX_CTL)) begin
			next_mux_rate_sel = bus_req.wdata[2:0];
		end
		if (wr_at(bus_req, `OFS_MEM_CTL)) begin
			next_display_mem_select = bus_req.wdata[`DISP_SEL_BIT];
			next_clear_blink_mem    = clear_blink_mem || bus_req.wdata[`CLR_BM_BIT];
		end
		// Self-clearing once the memory is wiped
		if (clear_blink_mem && frame_strobe) begin
			next_clear_blink_mem = 1'b0;
		end
		if (wr_at(bus_req, `OFS_VOLT_CTL)) begin
			next_lcd_voltage_level = bus_req.wdata[`VLEVEL_LSB +: 4];
			next_supply_select     = bus_req.wdata[`SUPPLY_SEL_BIT];
			next_ref_enable        = bus_req.wdata[`REF_EN_BIT];
			next_pump_enable       = bus_req.wdata[`PUMP_EN_BIT];
			next_auto_stop         = bus_req.wdata[`AUTO_STOP_BIT];
		end
	end

	// Frame-aligned selection and blink phase
	always_comb begin
		next_shown_mode = shown_mode;
		next_phase_on   = phase_on;
		next_show_blink = show_blink;
		if (frame_strobe) begin
			next_shown_mode = eff_mode;
			next_phase_on   = blink_clock;
			unique case (eff_mode)
				BLINK_NONE:    next_show_blink = display_mem_select && dual_ok;
				BLINK_SWAP:    next_show_blink = blink_clock;
				BLINK_SEGMENT: next_show_blink = 1'b0;
				BLINK_ALL:     next_show_blink = 1'b0;
			endcase
		end
	end

	// Segment drive and event flags
	always_comb begin
		src = show_blink ? bm_flat : seg_flat;
		next_segments = src;
		if (shown_mode == BLINK_ALL && !phase_on) begin
			next_segments = 128'h0;
		end else if (shown_mode == BLINK_SEGMENT && !phase_on) begin
			next_segments = src & ~bm_flat;
		end
		next_on_flag  = blink_on_flag;
		next_off_flag = blink_off_flag;
		// Writing any display or blink memory acknowledges both events
		if ((bus_req.wr && (seg_hit || bm_hit)) || wr_at(bus_req, `OFS_FLAGS)) begin
			next_on_flag  = blink_on_flag
				&& !(bus_req.wr && (seg_hit || bm_hit))
				&& !(wr_at(bus_req, `OFS_FLAGS) && bus_req.wdata[`ON_FLAG_BIT]);
			next_off_flag = blink_off_flag
				&& !(bus_req.wr && (seg_hit || bm_hit))
				&& !(wr_at(bus_req, `OFS_FLAGS) && bus_req.wdata[`OFF_FLAG_BIT]);
		end
		// Set after clear so a same-cycle event is kept
		if (eff_mode != BLINK_NONE && blink_clock && !bc_prev) begin
			next_on_flag = 1'b1;
		end
		if (eff_mode != BLINK_NONE && !blink_clock && bc_prev) begin
			next_off_flag = 1'b1;
		end
	end

	// Supply routing; the external capacitor carries the level while stopped
	always_comb begin
		next_supply.from_vdd  = supply_select && !ref_enable;
		next_supply.from_pump = !supply_select && pump_enable;
		next_supply.pump_run  = !supply_select && pump_enable && !quiet;
		next_supply.pump_hold = !supply_select && lcd_voltage_level != 4'h0
			&& (!pump_enable || quiet);
	end

	// Read data, valid in the cycle after the strobe only
	always_comb begin
		next_rdata = 16'h0000;
		if (bus_req.rd) begin
			if (seg_hit || bm_hit) begin
				next_rdata[7:0] = seg_hit ? seg_flat[lo_pos +: 8] : bm_flat[lo_pos +: 8];
				if (wide) begin
					next_rdata[15:8] = seg_hit ? seg_flat[hi_pos +: 8] : bm_flat[hi_pos +: 8];
				end
			end else begin
				unique case (bus_req.addr)
					`OFS_BLINK_CTL: next_rdata = {11'h000, blink_prescale, blink_mode_sel};
					`OFS_MUX_CTL:   next_rdata = {13'h0000, mux_rate_sel};
					`OFS_MEM_CTL:   next_rdata = {14'h0000, clear_blink_mem,
						(blink_mode_sel == BLINK_SWAP) ? show_blink : display_mem_select};
					`OFS_VOLT_CTL:  next_rdata = {8'h00, auto_stop, pump_enable, ref_enable,
						supply_select, lcd_voltage_level};
					`OFS_FLAGS:     next_rdata = {14'h0000, blink_off_flag, blink_on_flag};
					default:        next_rdata = 16'h0000;
				endcase
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			blink_mode_sel     <= BLINK_NONE;
			blink_prescale     <= `RST_PRE;
			mux_rate_sel       <= `RST_MUX;
			display_mem_select <= 1'b0;
			clear_blink_mem    <= 1'b0;
			lcd_voltage_level  <= `RST_VLEVEL;
			supply_select      <= 1'b0;
			ref_enable         <= 1'b0;
			pump_enable        <= 1'b0;
			auto_stop          <= 1'b0;
			shown_mode         <= BLINK_NONE;
			phase_on           <= 1'b0;
			show_blink         <= 1'b0;
			bc_prev            <= 1'b0;
			rdata              <= 16'h0000;
			segments           <= 128'h0;
			showing_blink_mem  <= 1'b0;
			blink_on_flag      <= 1'b0;
			blink_off_flag     <= 1'b0;
			supply             <= '0;
		end else begin
			blink_mode_sel     <= next_blink_mode_sel;
			blink_prescale     <= next_blink_prescale;
			mux_rate_sel       <= next_mux_rate_sel;
			display_mem_select <= next_display_mem_select;
			clear_blink_mem    <= next_clear_blink_mem;
			lcd_voltage_level  <= next_lcd_voltage_level;
			supply_select      <= next_supply_select;
			ref_enable         <= next_ref_enable;
			pump_enable        <= next_pump_enable;
			auto_stop          <= next_auto_stop;
			shown_mode         <= next_shown_mode;
			phase_on           <= next_phase_on;
			show_blink         <= next_show_blink;
			bc_prev            <= blink_clock;
			rdata              <= next_rdata;
			segments           <= next_segments;
			showing_blink_mem  <= next_show_blink;
			blink_on_flag      <= next_on_flag;
			blink_off_flag     <= next_off_flag;
			supply             <= next_supply;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence clear_at_frame;
		clear_blink_mem && frame_strobe;
	endsequence
	sequence swap_frame;
		frame_strobe && blink_mode_sel == BLINK_SWAP && dual_ok;
	endsequence

	chk_clear_frame: assert property (clear_at_frame |=> !clear_blink_mem && bm_flat == 128'h0)
		else $error("blink memory not cleared at frame");
	chk_clear_wait: assert property (clear_blink_mem && !frame_strobe |=> clear_blink_mem)
		else $error("clear left before frame boundary");
	chk_sel_stable: assert property (!frame_strobe |=> $stable(show_blink))
		else $error("memory source changed off frame");
	chk_manual_sel: assert property (
		frame_strobe && blink_mode_sel == BLINK_NONE && dual_ok
		|=> show_blink == $past(display_mem_select))
		else $error("manual memory select not followed");
	chk_swap_halves: assert property (swap_frame |=> show_blink == $past(blink_clock))
		else $error("swap half shows wrong memory");
	chk_blank_all: assert property (shown_mode == BLINK_ALL && !phase_on |=> segments == 128'h0)
		else $error("all-segment blink not blank");
	chk_seg_blink: assert property (
		shown_mode == BLINK_SEGMENT && !phase_on |=> (segments & $past(bm_flat)) == 128'h0)
		else $error("marked segment lit in off half");
	chk_high_mux: assert property (
		frame_strobe && !dual_ok && blink_mode_sel != BLINK_ALL |=> shown_mode == BLINK_NONE)
		else $error("blinking above 4-mux in unsupported mode");
	chk_phase_frame: assert property (frame_strobe |=> phase_on == $past(blink_clock))
		else $error("blink phase not taken at frame");
	chk_status_read: assert property (
		bus_req.rd && bus_req.addr == `OFS_MEM_CTL && blink_mode_sel == BLINK_SWAP
		|=> rdata[0] == $past(show_blink))
		else $error("select bit does not show displayed memory");
	chk_on_flag: assert property (
		eff_mode != BLINK_NONE && $rose(blink_clock) ##1 1'b1 |-> blink_on_flag)
		else $error("on flag missed blink clock rise");
	chk_supply_vdd: assert property (supply_select && !ref_enable |=> supply.from_vdd)
		else $error("main supply not selected");
	chk_pump_stop: assert property (!pump_enable |=> !supply.pump_run)
		else $error("pump running while disabled");
endmodule : lcd_blink_dual_memory_ctrl

// ==== verif/lcd_glass_model.sv ====
`timescale 1ns/1ps
// Glass stand-in: latches the pattern at each frame, dark when unpowered
module lcd_glass_model
	import lcd_blink_pkg::*;
(
	input  wire logic          clk,
	input  wire logic          reset,
	input  wire logic          frame_strobe,
	input  wire logic [127:0]  segments,
	input  wire supply_t       supply,
	output logic               powered,
	output logic      [127:0]  shown
);
	assign powered = supply.from_vdd | supply.from_pump;

	always_ff @(posedge clk) begin
		if (reset)
			shown <= 128'h0;
		else if (frame_strobe)
			shown <= powered ? segments : 128'h0;
	end
endmodule : lcd_glass_model

// ==== verif/tb_lcd_blink_dual_memory_ctrl.sv ====
`timescale 1ns/1ps
`include "lcd_blink_defs.svh"
module tb_lcd_blink_dual_memory_ctrl;
	import lcd_blink_pkg::*;
	logic          clk;
	logic          reset;
	reg_req_t      bus_req;
	logic          lcd_tick = 1'b0;
	logic          frame_strobe = 1'b0;
	logic          noise_window;
	logic [15:0]   rdata;
	logic [127:0]  segments;
	logic          showing_blink_mem;
	logic          blink_on_flag;
	logic          blink_off_flag;
	supply_t       supply;
	logic          powered;
	logic [127:0]  shown;
	logic [7:0]    seg_b [16];
	logic [7:0]    bm_b [16];
	logic [15:0]   rnd;
	logic          frames_on;
	logic          watch;
	logic [2:0]    fcnt = 3'h0;
	logic [2:0]    fs_hist = 3'h0;
	logic [127:0]  last_seg = 128'h0;
	logic [7:0]    corner [4];
	int            cyc = 0;
	int            n_mismatch;
	int            checks;

	lcd_blink_dual_memory_ctrl dut (.clk(clk), .reset(reset), .bus_req(bus_req),
		.lcd_tick(lcd_tick), .frame_strobe(frame_strobe), .noise_window(noise_window),
		.rdata(rdata), .segments(segments), .showing_blink_mem(showing_blink_mem),
		.blink_on_flag(blink_on_flag), .blink_off_flag(blink_off_flag), .supply(supply));

	lcd_glass_model glass (.clk(clk), .reset(reset), .frame_strobe(frame_strobe),
		.segments(segments), .supply(supply), .powered(powered), .shown(shown));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Tick every other cycle, frame every eighth
	always @(posedge clk) begin
		cyc <= cyc + 1;
		fcnt <= fcnt + 3'h1;
		lcd_tick <= fcnt[0];
		frame_strobe <= frames_on && (fcnt == 3'h7);
	end

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr

	function automatic logic [127:0] exp_seg(input logic [1:0] m, input logic [2:0] mx,
			input logic on, input logic disp);
		logic [127:0] s;
		logic [127:0] b;
		for (int i = 0; i < 16; i++) begin
			s[8*i +: 8] = seg_b[i];
			b[8*i +: 8] = bm_b[i];
		end
		if (mx > `MUX_DUAL_MAX)
			return (m == 2'b10 && !on) ? 128'h0 : s;
		case (m)
			2'b00: return disp ? b : s;
			2'b01: return on ? s : (s & ~b);
			2'b10: return on ? s : 128'h0;
			default: return on ? b : s;
		endcase
	endfunction : exp_seg

	task automatic check(input logic [127:0] got, input logic [127:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic w);
		@(posedge clk);
		bus_req <= '{addr: a, wdata: d, word: w, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus_req.wr <= 1'b0;
	endtask : wr

	task automatic check_rd(input logic [7:0] a, input logic w, input logic [15:0] exp);
		@(posedge clk);
		bus_req <= '{addr: a, wdata: 16'h0000, word: w, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus_req.rd <= 1'b0;
		@(negedge clk);
		check({112'h0, rdata}, {112'h0, exp});
	endtask : check_rd

	task automatic fill_mem();
		for (int i = 0; i < 16; i++) begin
			rnd = lfsr(rnd);
			seg_b[i] = rnd[7:0];
			bm_b[i] = rnd[15:8];
			wr(`OFS_SEG_MEM + 8'(i), {8'h00, seg_b[i]}, 1'b0);
		end
		for (int i = 0; i < 16; i += 2)
			wr(`OFS_BLINK_MEM + 8'(i), {bm_b[i+1], bm_b[i]}, 1'b1);
	endtask : fill_mem

	task automatic run_blink(input logic [1:0] m, input logic [2:0] mx, input logic [2:0] pre);
		int h;
		int t0;
		int t;
		logic on;
		h = (int'(mx) + 1) * (4 << pre);
		wr(`OFS_MUX_CTL, {13'h0, mx}, 1'b0);
		wr(`OFS_BLINK_CTL, {11'h0, pre, 2'b00}, 1'b0);
		// Byte 0 stands in for the panel's COM bits
		bm_b[0] = (m == 2'b01) ? 8'h00 : seg_b[0];
		wr(`OFS_BLINK_MEM, {8'h00, bm_b[0]}, 1'b0);
		wr(`OFS_BLINK_CTL, {11'h0, pre, m}, 1'b0);
		t0 = cyc;
		watch = 1'b1;
		// Sample mid-half only, clear of frame and tick phase slack
		repeat (4 * h) begin
			@(negedge clk);
			t = cyc - t0;
			on = ((t / h) % 2) == 1;
			if ((t % h) >= h / 4 && (t % h) < 3 * h / 4) begin
				check(segments, exp_seg(m, mx, on, 1'b0));
				if (m == 2'b11)
					check({127'h0, showing_blink_mem}, {127'h0, on});
			end
		end
		watch = 1'b0;
		if (m == 2'b11) begin
			repeat (h / 2) @(posedge clk);
			check_rd(`OFS_MEM_CTL, 1'b0, 16'h0000);
			repeat (h) @(posedge clk);
			check_rd(`OFS_MEM_CTL, 1'b0, 16'h0001);
		end
		wr(`OFS_BLINK_CTL, {11'h0, pre, 2'b00}, 1'b0);
		repeat (4) @(posedge clk);
		on = m == 2'b10 || (m != 2'b00 && mx <= `MUX_DUAL_MAX);
		check({126'h0, blink_off_flag, blink_on_flag}, on ? 128'h3 : 128'h0);
		check_rd(`OFS_FLAGS, 1'b0, on ? 16'h0003 : 16'h0000);
		wr(`OFS_FLAGS, 16'h0003, 1'b0);
		check_rd(`OFS_FLAGS, 1'b0, 16'h0000);
	endtask : run_blink

	// Segments may only move just after a frame strobe
	always @(negedge clk) begin
		if (watch && segments !== last_seg && fs_hist == 3'b000) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, segments, last_seg);
		end
		last_seg <= segments;
		fs_hist <= {fs_hist[1:0], frame_strobe};
	end

	task automatic give_verdict();
		$display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : give_verdict

	initial begin
		repeat (30000) @(posedge clk);
		n_mismatch++;
		give_verdict();
	end

	initial begin
		reset = 1'b1;
		bus_req = '0;
		noise_window = 1'b0;
		frames_on = 1'b0;
		watch = 1'b0;
		n_mismatch = 0;
		checks = 0;
		rnd = 16'h0034;
		corner = '{8'h10, 8'h40, 8'h45, 8'hc5};
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		for (int a = 0; a < 5; a++)
			check_rd(8'(a), 1'b0, 16'h0000);
		wr(8'h10, 16'h00ff, 1'b0);
		check_rd(8'h10, 1'b0, 16'h0000);
		fill_mem();
		check_rd(`OFS_SEG_MEM + 8'h05, 1'b0, {8'h00, seg_b[5]});
		check_rd(`OFS_BLINK_MEM + 8'h06, 1'b1, {bm_b[7], bm_b[6]});
		check_rd(`OFS_BLINK_MEM + 8'h03, 1'b1, {8'h00, bm_b[3]});
		wr(`OFS_MEM_CTL, 16'h0001, 1'b0);
		repeat (12) @(posedge clk);
		check({127'h0, showing_blink_mem}, 128'h0);
		frames_on <= 1'b1;
		repeat (12) @(posedge clk);
		check({127'h0, showing_blink_mem}, 128'h1);
		check(segments, exp_seg(2'b00, 3'h0, 1'b0, 1'b1));
		wr(`OFS_MEM_CTL, 16'h0000, 1'b0);
		repeat (12) @(posedge clk);
		check(segments, exp_seg(2'b00, 3'h0, 1'b0, 1'b0));
		frames_on <= 1'b0;
		wr(`OFS_MEM_CTL, 16'h0002, 1'b0);
		check_rd(`OFS_MEM_CTL, 1'b0, 16'h0002);
		check_rd(`OFS_BLINK_MEM + 8'h02, 1'b1, {bm_b[3], bm_b[2]});
		frames_on <= 1'b1;
		repeat (12) @(posedge clk);
		check_rd(`OFS_MEM_CTL, 1'b0, 16'h0000);
		check_rd(`OFS_BLINK_MEM + 8'h02, 1'b1, 16'h0000);
		fill_mem();
		run_blink(2'b10, 3'h1, 3'h3);
		run_blink(2'b01, 3'h3, 3'h2);
		run_blink(2'b11, 3'h0, 3'h4);
		run_blink(2'b01, 3'h4, 3'h2);
		run_blink(2'b10, 3'h7, 3'h1);
		run_blink(2'b00, 3'h2, 3'h3);
		for (int i = 0; i < 12; i++) begin
			logic [7:0] v;
			logic [4:0] e;
			logic [4:0] g;
			rnd = lfsr(rnd);
			v = (i < 4) ? corner[i] : rnd[7:0];
			noise_window <= rnd[8];
			wr(`OFS_VOLT_CTL, {8'h00, v}, 1'b0);
			// Long enough for one frame to reach the glass
			repeat (10) @(posedge clk);
			@(negedge clk);
			e[3] = v[4] & !v[5];
			e[2] = !v[4] & v[6];
			e[1] = !v[4] & v[6] & !(v[7] & rnd[8]);
			e[0] = !v[4] && v[3:0] != 4'h0 && (!v[6] || (v[7] && rnd[8]));
			e[4] = e[3] | e[2];
			g = {powered, supply.from_vdd, supply.from_pump, supply.pump_run, supply.pump_hold};
			check({123'h0, g}, {123'h0, e});
			check(shown, e[4] ? exp_seg(2'b00, 3'h2, 1'b0, 1'b0) : 128'h0);
		end
		give_verdict();
	end
endmodule : tb_lcd_blink_dual_memory_ctrl
